// ### nand_host_regs.svh
/*
  Constants for the NAND host sequencer: command codes, status bits, own
  register offsets and timing counts.
  Assumes a 20 MHz system clock and an 8-bit NAND device on plain pins.
*/
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_READ        8'h00
`define CMD_STATUS      8'h70
`define CMD_STATUS_MP   8'h71
`define CMD_RESET       8'hFF
`define CMD_ERASE1      8'h60
`define CMD_ERASE2      8'hD0
`define CMD_SERIAL_IN   8'h80
`define CMD_COL_CHANGE  8'h85
`define CMD_AUTO_PROG   8'h10
`define CMD_MULTI_PROG  8'h11
`define CMD_CACHE_PROG  8'h15
`define CMD_CACHE_READ  8'h31
`define CMD_READ2       8'h30

// ----------------------------------------------------------------------
// Status byte bits and bad-block mark
// ----------------------------------------------------------------------
`define ST_FAIL1        0
`define ST_FAIL2        1
`define ST_PB_READY     5
`define ST_CACHE_READY  6
`define ST_NOT_PROT     7
`define BAD_MARK        8'h00

// ----------------------------------------------------------------------
// Own register offsets
// ----------------------------------------------------------------------
`define OFF_CTRL        4'h0
`define OFF_ADDR        4'h1
`define OFF_STATUS      4'h2
`define OFF_NAND_STAT   4'h3
`define OFF_DATA        4'h4
`define OFF_BAD_LO      4'h5
`define OFF_BAD_HI      4'h6
`define OFF_GOOD_CNT    4'h7

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     2
`define CTRL_GO         3
`define CTRL_WP_EN      4

// ----------------------------------------------------------------------
// Timing and block/page limits
// ----------------------------------------------------------------------
`define CLK_NS          50
`define STROBE_NS       25
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define BLOCK_COUNT     13'h1000
`define GOOD_MIN        13'h0FB0
`define PAGE_MAX        6'h3F

`endif

// ### nand_host_pkg.sv
/*
  Types for the NAND host sequencer.
  Assumes the constants header is included by the design file.
*/
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_NONE, OP_RESET, OP_STATUS, OP_PROGRAM, OP_ERASE, OP_READ, OP_BADCHK
  } op_t;

  typedef struct packed {
    logic       cmd_latch;
    logic       addr_latch;
    logic       chip_en_n;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       write_prot_n;
  } nand_ctl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sw_req_t;

endpackage : nand_host_pkg

// ### nand_host.sv
/*
  NAND flash host sequencer: issues reset, status, program, erase, read and
  bad-block check sequences on the device pins and keeps a bad-block table.
  Assumes device pins synchronous to sys_clk and a software register port.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "nand_host_regs.svh"

module nand_host (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire nand_host_pkg::sw_req_t sw_req,
  output logic [7:0]                sw_rdata,
  output nand_host_pkg::nand_ctl_t  nand_ctl,
  output logic [7:0]                data_bus_out,
  output logic                      data_bus_oe,
  input  wire logic [7:0]           data_bus_bits,
  input  wire logic                 ready_busy_n
);
  import nand_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_DATA, S_CMD2, S_WAIT, S_STAT_CMD, S_STAT_RD,
    S_DATA_RD, S_DONE
  } state_t;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  state_t      state_reg;
  op_t         op_reg;
  logic [7:0]  cmd_reg;
  logic [2:0]  addr_idx_reg;
  logic [17:0] row_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  nstat_reg;
  logic [1:0]  phase_reg;
  logic        busy_reg;
  logic        fail_reg;
  logic        refused_reg;
  logic        wp_en_reg;
  logic [5:0]  last_page_reg;
  logic [11:0] last_blk_reg;
  logic        page_valid_reg;
  logic [12:0] good_cnt_reg;
  logic [4095:0] bad_tbl_reg;
  logic        init_done_reg;
  logic [2:0]  op_req;
  logic        go;
  logic [11:0] blk;
  logic [5:0]  page;
  logic [23:0] row_bytes;
  logic [2:0]  row_idx;

  assign blk  = row_reg[17:6];
  assign page = row_reg[5:0];
  assign row_bytes = {6'h00, row_reg};
  assign row_idx = (op_reg == OP_ERASE) ? addr_idx_reg : addr_idx_reg - 3'h2;
  assign op_req = sw_req.wdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
  assign go = sw_req.wr && sw_req.addr == `OFF_CTRL &&
              sw_req.wdata[`CTRL_GO] && state_reg == S_IDLE;

  // ----------------------------------------------------------------------
  // Request acceptance and guard checks
  // ----------------------------------------------------------------------
  logic start_ok;
  always_comb begin
    start_ok = 1'b1;
    if ((!init_done_reg || !ready_busy_n) && op_t'(op_req) != OP_RESET &&
        op_t'(op_req) != OP_STATUS) begin
      start_ok = 1'b0;
    end
    if ((op_t'(op_req) == OP_ERASE || op_t'(op_req) == OP_PROGRAM) &&
        bad_tbl_reg[blk]) begin
      start_ok = 1'b0;
    end
    if (op_t'(op_req) == OP_PROGRAM && page_valid_reg &&
        blk == last_blk_reg && page <= last_page_reg) begin
      start_ok = 1'b0;
    end
    if (op_t'(op_req) == OP_NONE) begin
      start_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg    <= S_IDLE;
      op_reg       <= OP_NONE;
      cmd_reg      <= 8'h00;
      addr_idx_reg <= 3'h0;
      phase_reg    <= 2'h0;
      busy_reg     <= 1'b0;
      refused_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
      nstat_reg    <= 8'h00;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            refused_reg <= !start_ok;
            if (start_ok) begin
              op_reg    <= op_t'(op_req);
              busy_reg  <= 1'b1;
              phase_reg <= 2'h0;
              case (op_t'(op_req))
                OP_RESET:   cmd_reg <= `CMD_RESET;
                OP_STATUS:  cmd_reg <= `CMD_STATUS;
                OP_PROGRAM: cmd_reg <= `CMD_SERIAL_IN;
                OP_ERASE:   cmd_reg <= `CMD_ERASE1;
                default:    cmd_reg <= `CMD_READ;
              endcase
              state_reg <= S_CMD;
            end
          end
        end
        S_CMD: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            phase_reg    <= 2'h0;
            addr_idx_reg <= 3'h0;
            case (op_reg)
              OP_RESET:  state_reg <= S_WAIT;
              OP_STATUS: state_reg <= S_STAT_RD;
              default:   state_reg <= S_ADDR;
            endcase
          end
        end
        S_ADDR: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            phase_reg    <= 2'h0;
            addr_idx_reg <= addr_idx_reg + 3'h1;
            // Five cycles are sent, three for erase; a sixth is never needed.
            if ((op_reg == OP_ERASE && addr_idx_reg == 3'h2) ||
                addr_idx_reg == 3'h4) begin
              if (op_reg == OP_PROGRAM) begin
                state_reg <= S_DATA;
              end else begin
                cmd_reg   <= (op_reg == OP_ERASE) ? `CMD_ERASE2
                                                  : `CMD_READ2;
                state_reg <= S_CMD2;
              end
            end
          end
        end
        S_DATA: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            phase_reg <= 2'h0;
            cmd_reg   <= `CMD_AUTO_PROG;
            state_reg <= S_CMD2;
          end
        end
        S_CMD2: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            phase_reg <= 2'h0;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (ready_busy_n) begin
            case (op_reg)
              OP_PROGRAM, OP_ERASE: begin
                cmd_reg   <= `CMD_STATUS;
                state_reg <= S_STAT_CMD;
              end
              OP_READ, OP_BADCHK: begin
                cmd_reg   <= `CMD_READ;
                state_reg <= S_DATA_RD;
              end
              default: state_reg <= S_DONE;
            endcase
          end
        end
        S_STAT_CMD: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            phase_reg <= 2'h0;
            state_reg <= S_STAT_RD;
          end
        end
        S_STAT_RD: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            nstat_reg <= data_bus_bits;
            state_reg <= S_DONE;
          end
        end
        S_DATA_RD: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'(`STROBE_CYC)) begin
            rdata_reg <= data_bus_bits;
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          busy_reg  <= 1'b0;
          phase_reg <= 2'h0;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outcome tracking and bad-block table
  // ----------------------------------------------------------------------
  logic status_fail;
  always_comb begin
    status_fail = nstat_reg[`ST_PB_READY] && nstat_reg[`ST_FAIL1];
    if (cmd_reg == `CMD_CACHE_PROG && nstat_reg[`ST_CACHE_READY]) begin
      status_fail = status_fail || nstat_reg[`ST_FAIL2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fail_reg       <= 1'b0;
      bad_tbl_reg    <= '0;
      good_cnt_reg   <= `BLOCK_COUNT;
      last_page_reg  <= 6'h00;
      last_blk_reg   <= 12'h000;
      page_valid_reg <= 1'b0;
    end else if (state_reg == S_DONE) begin
      fail_reg <= 1'b0;
      if ((op_reg == OP_PROGRAM || op_reg == OP_ERASE) && status_fail) begin
        fail_reg <= 1'b1;
        if (!bad_tbl_reg[blk]) begin
          bad_tbl_reg[blk] <= 1'b1;
          good_cnt_reg     <= good_cnt_reg - 13'h0001;
        end
      end
      if (op_reg == OP_BADCHK && rdata_reg == `BAD_MARK &&
          !bad_tbl_reg[blk]) begin
        bad_tbl_reg[blk] <= 1'b1;
        good_cnt_reg     <= good_cnt_reg - 13'h0001;
      end
      if (op_reg == OP_PROGRAM) begin
        last_page_reg  <= page;
        last_blk_reg   <= blk;
        page_valid_reg <= page != `PAGE_MAX;
      end
      if (op_reg == OP_ERASE || op_reg == OP_RESET) begin
        page_valid_reg <= 1'b0;
      end
    end else if (go) begin
      fail_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      init_done_reg <= 1'b0;
    end else if (ready_busy_n) begin
      init_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      row_reg   <= 18'h0_0000;
      wdata_reg <= 8'h00;
      wp_en_reg <= 1'b0;
    end else if (sw_req.wr) begin
      case (sw_req.addr)
        `OFF_CTRL:   wp_en_reg <= sw_req.wdata[`CTRL_WP_EN];
        `OFF_ADDR:   row_reg <= {row_reg[9:0], sw_req.wdata};
        `OFF_DATA:   wdata_reg <= sw_req.wdata;
        default:     wdata_reg <= wdata_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_rdata <= 8'h00;
    end else if (sw_req.rd) begin
      case (sw_req.addr)
        `OFF_CTRL:      sw_rdata <= {3'h0, wp_en_reg, 4'h0};
        `OFF_STATUS:    sw_rdata <= {4'h0, good_cnt_reg < `GOOD_MIN,
                                     refused_reg, fail_reg, busy_reg};
        `OFF_NAND_STAT: sw_rdata <= nstat_reg;
        `OFF_DATA:      sw_rdata <= rdata_reg;
        `OFF_BAD_LO:    sw_rdata <= {7'h00, bad_tbl_reg[blk]};
        `OFF_GOOD_CNT:  sw_rdata <= good_cnt_reg[12:5];
        default:        sw_rdata <= 8'h00;
      endcase
    end else begin
      sw_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nand_ctl     <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      data_bus_out <= 8'h00;
      data_bus_oe  <= 1'b0;
    end else begin
      nand_ctl.write_prot_n <= wp_en_reg;
      nand_ctl.chip_en_n    <= state_reg == S_IDLE;
      nand_ctl.cmd_latch    <= state_reg == S_CMD || state_reg == S_CMD2 ||
                               state_reg == S_STAT_CMD;
      nand_ctl.addr_latch   <= state_reg == S_ADDR;
      nand_ctl.write_strobe_n <= !((state_reg == S_CMD ||
          state_reg == S_CMD2 || state_reg == S_STAT_CMD ||
          state_reg == S_ADDR || state_reg == S_DATA) && phase_reg == 2'h0);
      nand_ctl.read_strobe_n <= !((state_reg == S_STAT_RD ||
          state_reg == S_DATA_RD) && phase_reg == 2'h0);
      data_bus_oe <= state_reg == S_CMD || state_reg == S_CMD2 ||
                     state_reg == S_STAT_CMD || state_reg == S_ADDR ||
                     state_reg == S_DATA;
      case (state_reg)
        S_ADDR:  data_bus_out <= (addr_idx_reg < 3'h2 &&
                                  op_reg != OP_ERASE) ? 8'h00
                                 : row_bytes[{row_idx[1:0], 3'b000} +: 8];
        S_DATA:  data_bus_out <= wdata_reg;
        default: data_bus_out <= cmd_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_busy_cmd_only: assert property (
    (go && !ready_busy_n && op_t'(op_req) == OP_PROGRAM) |=> refused_reg)
    else $error("Program accepted while busy.");
  a_bad_erase_block: assert property (
    (go && op_t'(op_req) == OP_ERASE && bad_tbl_reg[blk]) |=>
    state_reg == S_IDLE)
    else $error("Erase started on bad block.");
  a_wp_follows_ctrl: assert property (
    $changed(wp_en_reg) |=> nand_ctl.write_prot_n == $past(wp_en_reg))
    else $error("Write protect pin lags control.");
  a_init_reset_only: assert property (
    (state_reg == S_CMD && !init_done_reg) |->
    (cmd_reg == `CMD_RESET || cmd_reg == `CMD_STATUS))
    else $error("Illegal command during init.");
  a_fail_marks_bad: assert property (
    (state_reg == S_DONE && op_reg == OP_ERASE && status_fail) |=>
    bad_tbl_reg[$past(blk)])
    else $error("Failed block not recorded.");
  a_wait_for_ready: assert property (
    (state_reg == S_WAIT && !ready_busy_n) |=> state_reg == S_WAIT)
    else $error("Left wait while busy.");
  a_status_cmd_code: assert property (
    (state_reg == S_STAT_CMD) |-> cmd_reg == `CMD_STATUS)
    else $error("Wrong status command.");
  a_page_ascending: assert property (
    (go && op_t'(op_req) == OP_PROGRAM && page_valid_reg &&
     blk == last_blk_reg && page <= last_page_reg) |=> refused_reg)
    else $error("Page order not enforced.");

endmodule : nand_host

// ### nand_dev_model.sv
/*
  Behavioural model of the NAND device on the far side of the host block.
  Assumes pins that change just after sys_clk edges; the bench resolves the
  shared data bus and the pulled-up ready/busy line.
*/
`timescale 1ns/1ps
`include "nand_host_regs.svh"
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter int INIT_CYC = 200,
  parameter int OP_CYC   = 30
) (
  input  wire logic       sys_clk,
  input  wire nand_ctl_t  ctl,
  input  wire logic [7:0] dq_in,
  output logic [7:0]      dq_out,
  output logic            busy,
  input  wire logic       fail_prog,
  input  wire logic       fail_erase,
  input  wire logic       hold_busy
);
  logic [7:0]  mem [int];
  bit          bad [int];
  int          last_pg [int];
  logic [7:0]  ab [0:5];
  logic [7:0]  dat, rd_byte, last_q, status;
  int          cyc, busy_until, na, violations, resets, erases;
  logic        fail1, stat_mode, serial, erasing;

  // ----------------------------------------------------------------------
  // Status byte and data output
  // ----------------------------------------------------------------------
  assign busy   = (cyc < busy_until) || hold_busy;
  assign status = {ctl.write_prot_n, ~busy, ~busy, 4'h0,
                   fail1 & ~busy};
  // A released bus shows the inverse of its last value.
  assign dq_out = (!ctl.chip_en_n && !ctl.read_strobe_n) ?
                  (stat_mode ? status : rd_byte) : ~last_q;

  initial begin
    cyc = 0;
    busy_until = INIT_CYC;
    na = 0;
    violations = 0;
    resets = 0;
    erases = 0;
    fail1 = 1'b0;
    stat_mode = 1'b0;
    serial = 1'b0;
    erasing = 1'b0;
    last_q = 8'h00;
    rd_byte = 8'hFF;
    dat = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Command decoding
  // ----------------------------------------------------------------------
  task automatic command(input logic [7:0] c);
    logic [23:0] r;
    logic [11:0] blk;
    r = erasing ? {ab[2], ab[1], ab[0]} : {ab[4], ab[3], ab[2]};
    blk = r[17:6];
    if (!(c inside {`CMD_READ, `CMD_READ2, `CMD_CACHE_READ, `CMD_ERASE1,
        `CMD_ERASE2, `CMD_STATUS, `CMD_STATUS_MP, `CMD_SERIAL_IN,
        `CMD_COL_CHANGE, `CMD_AUTO_PROG, `CMD_MULTI_PROG,
        `CMD_CACHE_PROG, `CMD_RESET}))
      violations++;
    if (busy && !(c inside {`CMD_STATUS, `CMD_STATUS_MP, `CMD_RESET})) begin
      violations++;
      return;
    end
    if (serial && !(c inside {`CMD_COL_CHANGE, `CMD_AUTO_PROG,
        `CMD_MULTI_PROG, `CMD_CACHE_PROG, `CMD_RESET})) begin
      violations++;
      serial = 1'b0;
    end
    case (c)
      `CMD_RESET: begin
        serial = 1'b0;
        erasing = 1'b0;
        stat_mode <= 1'b0;
        fail1 <= 1'b0;
        resets++;
        busy_until <= cyc + 5;
      end
      `CMD_STATUS, `CMD_STATUS_MP: stat_mode <= 1'b1;
      `CMD_READ: begin
        stat_mode <= 1'b0;
        na = 0;
      end
      `CMD_SERIAL_IN: begin
        serial = 1'b1;
        na = 0;
        stat_mode <= 1'b0;
      end
      `CMD_ERASE1: begin
        erasing = 1'b1;
        na = 0;
        stat_mode <= 1'b0;
      end
      `CMD_AUTO_PROG: begin
        serial = 1'b0;
        if (last_pg.exists(blk) && int'(r[5:0]) <= last_pg[blk])
          violations++;
        if (ctl.write_prot_n) begin
          mem[int'(r[17:0])] = dat;
          last_pg[blk] = int'(r[5:0]);
          fail1 <= fail_prog;
          busy_until <= cyc + OP_CYC;
        end
      end
      `CMD_ERASE2: begin
        erasing = 1'b0;
        if (bad.exists(blk))
          violations++;
        if (ctl.write_prot_n) begin
          erases++;
          last_pg.delete(blk);
          fail1 <= fail_erase;
          busy_until <= cyc + OP_CYC;
        end
      end
      `CMD_READ2: begin
        rd_byte <= bad.exists(blk) ? `BAD_MARK :
                   (mem.exists(int'(r[17:0])) ? mem[int'(r[17:0])] : 8'hFF);
        busy_until <= cyc + 10;
      end
      default: ;
    endcase
  endtask : command

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!ctl.chip_en_n && !ctl.read_strobe_n)
      last_q <= dq_out;
    if (!ctl.chip_en_n && !ctl.write_strobe_n) begin
      if (ctl.cmd_latch)
        command(dq_in);
      else if (ctl.addr_latch) begin
        if (na < 5)
          ab[na] = dq_in;
        na++;
      end else
        dat = dq_in;
    end
  end
endmodule : nand_dev_model

// ### nand_host_bench.sv
/*
  Self-checking bench for the NAND host sequencer against the device model.
  Assumes the constants header and the package are compiled first.
*/
`timescale 1ns/1ps
`include "nand_host_regs.svh"
module nand_host_bench;
  import nand_host_pkg::*;
  logic       sys_clk, reset, fail_prog, fail_erase, hold_busy, dev_busy;
  logic       data_bus_oe, ready_busy_n;
  logic [7:0] sw_rdata, data_bus_out, data_bus_bits, dev_dq, st;
  sw_req_t    sw_req;
  nand_ctl_t  nand_ctl;
  int         failures, compares;
  int         cycles = 0;

  assign ready_busy_n  = dev_busy ? 1'b0 : 1'b1;
  assign data_bus_bits = data_bus_oe ? data_bus_out : dev_dq;

  nand_host uut (.sys_clk(sys_clk), .reset(reset), .sw_req(sw_req),
    .sw_rdata(sw_rdata), .nand_ctl(nand_ctl), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .data_bus_bits(data_bus_bits),
    .ready_busy_n(ready_busy_n));
  nand_dev_model dev (.sys_clk(sys_clk), .ctl(nand_ctl),
    .dq_in(data_bus_bits), .dq_out(dev_dq), .busy(dev_busy),
    .fail_prog(fail_prog), .fail_erase(fail_erase), .hold_busy(hold_busy));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    sw_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    sw_req <= '0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    sw_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    sw_req <= '0;
    @(posedge sys_clk);
    d = sw_rdata;
  endtask : rd

  task automatic run(input logic [2:0] op, input logic [11:0] blk,
                     input logic [5:0] pg, input logic wp);
    logic [17:0] r;
    int          n;
    r = {blk, pg};
    wr(`OFF_ADDR, {6'h00, r[17:16]});
    wr(`OFF_ADDR, r[15:8]);
    wr(`OFF_ADDR, r[7:0]);
    wr(`OFF_CTRL, {3'b000, ~wp, 1'b1, op});
    n = 0;
    do begin
      rd(`OFF_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    if (n >= 400)
      failures++;
  endtask : run

  task automatic endt(input string name);
    $display("Test %s finished", name);
  endtask : endt

  task automatic give_verdict();
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    failures = 0;
    compares = 0;
    reset = 1'b1;
    sw_req = '0;
    fail_prog = 1'b0;
    fail_erase = 1'b0;
    hold_busy = 1'b0;
    dev.bad[9] = 1'b1;
    repeat (7) @(posedge sys_clk);
    check("pins_idle", {2'b00, nand_ctl}, 8'h0E);
    check("bus_oe", {7'h00, data_bus_oe}, 8'h00);
    @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    run(OP_PROGRAM, 12'h005, 6'h02, 1'b0);
    check("early_prog", st, 8'h04);
    run(OP_STATUS, 12'h000, 6'h00, 1'b0);
    check("early_stat", st & 8'h04, 8'h00);
    run(OP_RESET, 12'h000, 6'h00, 1'b0);
    check("reset_st", st, 8'h00);
    check("resets", 8'(dev.resets), 8'h01);
    endt("power_up");
    wr(`OFF_DATA, 8'h3C);
    run(OP_PROGRAM, 12'h005, 6'h02, 1'b0);
    check("prog_st", st, 8'h00);
    check("prog_mem", dev.mem[32'h0000_0142], 8'h3C);
    rd(`OFF_NAND_STAT, st);
    check("nand_stat", st, 8'hE0);
    run(OP_PROGRAM, 12'h005, 6'h01, 1'b0);
    check("page_down", st, 8'h04);
    run(OP_PROGRAM, 12'h005, 6'h03, 1'b0);
    check("page_up", st, 8'h00);
    endt("program");
    run(OP_PROGRAM, 12'h007, 6'h00, 1'b1);
    rd(`OFF_NAND_STAT, st);
    check("wp_stat", st & 8'h80, 8'h00);
    check("wp_mem", 8'(dev.mem.exists(32'h0000_01C0)), 8'h00);
    endt("protect");
    fail_prog <= 1'b1;
    run(OP_PROGRAM, 12'h006, 6'h00, 1'b0);
    check("prog_fail", st, 8'h02);
    fail_prog <= 1'b0;
    run(OP_PROGRAM, 12'h006, 6'h01, 1'b0);
    check("prog_retired", st, 8'h04);
    fail_erase <= 1'b1;
    run(OP_ERASE, 12'h00A, 6'h00, 1'b0);
    check("erase_fail", st, 8'h02);
    fail_erase <= 1'b0;
    run(OP_ERASE, 12'h00A, 6'h00, 1'b0);
    check("erase_retired", st, 8'h04);
    endt("failures");
    run(OP_BADCHK, 12'h009, 6'h00, 1'b0);
    rd(`OFF_BAD_LO, st);
    check("bad_found", st, 8'h01);
    run(OP_ERASE, 12'h009, 6'h00, 1'b0);
    check("bad_erase", st, 8'h04);
    check("erase_count", 8'(dev.erases), 8'h01);
    run(OP_BADCHK, 12'h008, 6'h00, 1'b0);
    rd(`OFF_BAD_LO, st);
    check("good_found", st, 8'h00);
    rd(`OFF_GOOD_CNT, st);
    check("good_cnt", st, 8'h7F);
    endt("bad_blocks");
    run(OP_READ, 12'h005, 6'h02, 1'b0);
    rd(`OFF_DATA, st);
    check("read_data", st, 8'h3C);
    hold_busy <= 1'b1;
    run(OP_PROGRAM, 12'h00B, 6'h00, 1'b0);
    check("busy_prog", st, 8'h04);
    hold_busy <= 1'b0;
    run(OP_NONE, 12'h00B, 6'h00, 1'b0);
    check("op_none", st, 8'h04);
    check("violations", 8'(dev.violations), 8'h00);
    endt("commands");
    give_verdict();
  end
endmodule : nand_host_bench
